// [design/pmrl_pkg.sv]
/*
 * Constants for the pin-mode and reset logic: register offsets, field
 * positions, reset values, delay figures and decode enumerations.
 * Assumes a 100 MHz clock; counts are derived from it here.
 */
package pmrl_pkg;

  localparam int CLK_MHZ = 100;

  // Register offsets of the per-pin delay registers
  localparam logic [7:0] PIN_DLY_A_OFS = 8'h0b;
  localparam logic [7:0] PIN_DLY_B_OFS = 8'h0c;
  localparam logic [7:0] PIN_DLY_C_OFS = 8'h27;
  localparam logic [7:0] PIN_DLY_D_OFS = 8'h28;
  // Control registers that steer this block, then status readback and an unused mode offset
  localparam logic [7:0] RST_SEL_OFS   = 8'h40;
  localparam logic [7:0] RST_CFG_OFS   = 8'h41;
  localparam logic [7:0] PIN_FUNC_OFS  = 8'h42;
  localparam logic [7:0] PIN_SRC_OFS   = 8'h43;
  localparam logic [7:0] EXTRA_DLY_OFS = 8'h44;
  localparam logic [7:0] EXTRA_DLY2_OFS = 8'h45;
  localparam logic [7:0] STATUS_OFS    = 8'h46;
  localparam logic [7:0] MODE_OFS      = 8'h47;

  localparam logic [7:0] PIN_DLY_RST   = 8'h00;
  localparam logic [7:0] RST_SEL_RST   = 8'h3f;
  localparam logic [7:0] RST_CFG_RST   = 8'h01;
  localparam logic [7:0] PIN_FUNC_RST  = 8'h00;
  localparam logic [7:0] PIN_SRC_RST   = 8'h00;
  localparam logic [7:0] EXTRA_DLY_RST = 8'h00;

  // Field positions in the reset config register
  localparam int RST_CFG_DIS_MASK_BIT = 0;
  localparam int RST_CFG_DLY_LSB      = 1;

  // External-supply enable delays in microseconds, codes ascending
  localparam int EXT_DLY_US [8] = '{0, 250, 500, 750, 1000, 2000, 4000, 8000};
  // Reset-release delays in microseconds
  localparam int REL_DLY_US [8] = '{500, 1000, 2000, 4000, 8000, 16000,
                                    32000, 64000};
  // Extra start-up delays in microseconds
  localparam int XTRA_DLY_US [4] = '{0, 750, 1500, 2250};
  localparam int CYC_PER_US = CLK_MHZ;

  typedef enum logic [1:0] {
    PMRL_LVL_LOW,
    PMRL_LVL_FLOAT,
    PMRL_LVL_HIGH
  } pmrl_level_t;

  typedef enum logic [1:0] {
    PMRL_OP_BUCK,
    PMRL_OP_LDO,
    PMRL_OP_LSW
  } pmrl_op_t;

  typedef enum logic [1:0] {
    PMRL_PF_GPIO_IN,
    PMRL_PF_EXT_SUPPLY_ENABLE,
    PMRL_PF_POK_OUT,
    PMRL_PF_REG_OUT
  } pmrl_pinfunc_t;

endpackage

// [design/pmrl_delay_timer.sv]
/*
 * Delay timer: after arm_in rises, fires done_out once the programmed
 * count elapses; drops done_out on the next clock edge after arm_in falls.
 * Assumes a single clock and a count stable while armed.
 */
`timescale 1ns/1ps
module pmrl_delay_timer #(
  parameter int CW = 23
) (
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic          arm_in,
  input  wire logic [CW-1:0] count_in,
  output logic               done_out
);
  logic [CW-1:0] cnt_q;
  logic          done_q;
  wire           reached = (cnt_q >= count_in);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (!arm_in) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (!reached) begin
      cnt_q  <= cnt_q + 1'b1;
    end else begin
      done_q <= 1'b1;
    end
  end

  assign done_out = done_q;
endmodule

// [design/pmrl_pin_sync.sv]
/*
 * Three-stage synchroniser for pin levels; output changes only once the
 * second and third stages agree.
 * Assumes asynchronous pin inputs.
 */
`timescale 1ns/1ps
module pmrl_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level_out = lvl_q;
endmodule

// [design/pmrl_core.sv]
/*
 * Pin-mode and reset logic: reset generation from power-ok flags,
 * external-supply enable with delay, pin functions, extra start-up
 * delay and strap decoding of regulator modes and presets.
 * Assumes a simple byte register port and asynchronous straps/pins.
 */
// Notes on behaviour
// - Reset output low when any contributing regulator reports not good.
// - Each regulator has a bit choosing whether it feeds the reset.
// - Config bit decides if disabled regulators are ignored; default ignores.
// - External enable follows chosen power-ok after 0 to 8 ms delay.
// - External power-good input can trigger one regulator's start.
// - Any regulator's power-ok can be routed to a pin.
// - Register-driven open-drain pins 0..4 follow their register bit; pins 5..7 stay driven low.
// - Extra delay 0/0.75/1.5/2.25 ms for Buck4/LDO1/LDO2 per delay-strap level; LDO2 low is zero.
// - Regulator starts after normal delay plus extra delay.
// - Buck1 strap: high bypass, float preset 0, low preset 1.
// - Buck2 strap: high preset 0, low preset 1.
// - LDO2 strap: high regulating, low load switch.
// - Buck3 strap: high/float/low select presets 0/1/2.
// - Buck4 strap: high preset 0, float preset 1, low LDO preset 2.
// - LDO1 strap: high LDO preset 0, float bypass, low preset 1.
// - Preset values are unconstrained; no ordering is checked.
// - Shared Buck1/Buck2 strap: Buck2 preset from hi or lo bit.
// - Shared LDO1/Buck4 strap: Buck4 buck preset 0 on high or low.
// - Shared strap floating: Buck4 buck preset 1 or LDO preset 2.
// - Reset released after programmable 0.5 to 64 ms once rails good.
`timescale 1ns/1ps
module pmrl_core #(
  parameter int NREG  = 6,
  parameter int NPIN  = 8,
  parameter int CW    = 23
) (
  input  wire logic            clk_in,
  input  wire logic            rstn_in,
  // Register port
  input  wire logic            reg_wr_in,
  input  wire logic [7:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  output logic      [7:0]      reg_rdata_out,
  // Regulator status and control
  input  wire logic [NREG-1:0] power_ok_in,
  input  wire logic [NREG-1:0] reg_enabled_in,
  input  wire logic [NREG-1:0] start_req_in,
  input  wire logic [2:0]      startup_sel_in,
  output logic      [NREG-1:0] reg_start_out,
  // Strap inputs: low and high detect for three-state pins
  input  wire logic [1:0]      strap_buck1_in,
  input  wire logic            strap_buck2_in,
  input  wire logic [1:0]      strap_buck3_in,
  input  wire logic [1:0]      strap_ldo1_in,
  input  wire logic            strap_ldo2_in,
  input  wire logic [1:0]      strap_delay_in,
  input  wire logic            shared_pin_buck12_option_in,
  input  wire logic            buck2_shared_preset_hi_in,
  input  wire logic            buck2_shared_preset_lo_in,
  input  wire logic            shared_pin_ldo1_b4_option_in,
  input  wire logic            b4_default_operation_in,
  input  wire logic            strap_sample_in,
  // Pins
  input  wire logic [NPIN-1:0] gpio_in,
  output logic      [NPIN-1:0] gpio_out,
  output logic      [NPIN-1:0] gpio_oe_out,
  output logic                 system_reset_out_n,
  output logic                 system_reset_oe_out,
  // Decoded modes
  output logic      [1:0]      buck1_op_out,
  output logic      [1:0]      buck1_preset_out,
  output logic      [1:0]      buck2_preset_out,
  output logic      [1:0]      buck3_preset_out,
  output logic      [1:0]      buck4_op_out,
  output logic      [1:0]      buck4_preset_out,
  output logic      [1:0]      ldo1_op_out,
  output logic      [1:0]      ldo1_preset_out,
  output logic      [1:0]      ldo2_op_out
);
  // Registers
  logic [7:0] pin_dly_q [4];
  logic [7:0] rst_sel_q;
  logic [7:0] rst_cfg_q;
  logic [7:0] pin_func_lo_q;
  logic [7:0] pin_src_q;
  logic [7:0] xtra_q;
  logic [7:0] xtra2_q;
  logic [7:0] mode_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 4; i++) begin
        pin_dly_q[i] <= pmrl_pkg::PIN_DLY_RST;
      end
      rst_sel_q     <= pmrl_pkg::RST_SEL_RST;
      rst_cfg_q     <= pmrl_pkg::RST_CFG_RST;
      pin_func_lo_q <= pmrl_pkg::PIN_FUNC_RST;
      pin_src_q     <= pmrl_pkg::PIN_SRC_RST;
      xtra_q        <= pmrl_pkg::EXTRA_DLY_RST;
      xtra2_q       <= pmrl_pkg::EXTRA_DLY_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        pmrl_pkg::PIN_DLY_A_OFS:  pin_dly_q[0]  <= reg_wdata_in;
        pmrl_pkg::PIN_DLY_B_OFS:  pin_dly_q[1]  <= reg_wdata_in;
        pmrl_pkg::PIN_DLY_C_OFS:  pin_dly_q[2]  <= reg_wdata_in;
        pmrl_pkg::PIN_DLY_D_OFS:  pin_dly_q[3]  <= reg_wdata_in;
        pmrl_pkg::RST_SEL_OFS:    rst_sel_q     <= reg_wdata_in;
        pmrl_pkg::RST_CFG_OFS:    rst_cfg_q     <= reg_wdata_in;
        pmrl_pkg::PIN_FUNC_OFS:   pin_func_lo_q <= reg_wdata_in;
        pmrl_pkg::PIN_SRC_OFS:    pin_src_q     <= reg_wdata_in;
        pmrl_pkg::EXTRA_DLY_OFS:  xtra_q        <= reg_wdata_in;
        pmrl_pkg::EXTRA_DLY2_OFS: xtra2_q       <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Pin field layout: each delay register holds two pins, 3-bit delay
  // in bits 2:0 / 6:4 and the function in bits 3 / 7 with pin_func_lo
  // supplying the second function bit.
  // Pin source register: bits 2:0 regulator for enable/pok pins,
  // bits 7:3 level bits for register-driven pins 0..4.

  // Reset generation
  wire [NREG-1:0] ok_or_ignored;
  wire            dis_ignored = rst_cfg_q[pmrl_pkg::RST_CFG_DIS_MASK_BIT];
  wire            rails_good;
  wire [2:0]      rel_code = rst_cfg_q[pmrl_pkg::RST_CFG_DLY_LSB +: 3];
  logic [CW-1:0]  rel_count;
  logic           rel_done;

  // Disabled rails drop out only when configured so
  assign ok_or_ignored = power_ok_in | ~rst_sel_q[NREG-1:0]
                       | (dis_ignored ? ~reg_enabled_in : '0);
  assign rails_good    = &ok_or_ignored;

  always_comb begin
    rel_count = '0;
    for (int k = 0; k < 8; k++) begin
      if (rel_code == 3'(k)) begin
        rel_count = CW'(pmrl_pkg::REL_DLY_US[k] * pmrl_pkg::CYC_PER_US);
      end
    end
  end

  pmrl_delay_timer #(.CW(CW)) u_rel (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .arm_in   (rails_good),
    .count_in (rel_count),
    .done_out (rel_done)
  );

  // Open drain: drive low only; released reset floats high
  assign system_reset_out_n  = 1'b0;
  assign system_reset_oe_out = ~rel_done;

  // Pin inputs synchronised
  logic [NPIN-1:0] gpio_sync;
  pmrl_pin_sync #(.W(NPIN)) u_gsync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (gpio_in),
    .level_out (gpio_sync)
  );

  // Regulator index shared by enable and power-ok outputs
  wire [2:0] src_reg = pin_src_q[2:0];
  wire       src_pok = (src_reg < 3'(NREG)) ? power_ok_in[src_reg] : 1'b0;

  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_pin
      wire [7:0]  dreg  = pin_dly_q[p/2];
      wire [2:0]  dcode = dreg[(p%2)*4 +: 3];
      wire [1:0]  func  = {dreg[(p%2)*4+3], pin_func_lo_q[p]};
      logic [CW-1:0] dcount;
      logic          en_done;

      always_comb begin
        dcount = '0;
        for (int k = 0; k < 8; k++) begin
          if (dcode == 3'(k)) begin
            dcount = CW'(pmrl_pkg::EXT_DLY_US[k] * pmrl_pkg::CYC_PER_US);
          end
        end
      end

      pmrl_delay_timer #(.CW(CW)) u_ext (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .arm_in   (func == pmrl_pkg::PMRL_PF_EXT_SUPPLY_ENABLE && src_pok),
        .count_in (dcount),
        .done_out (en_done)
      );

      wire reg_lvl = (p < 5) ? pin_src_q[3 + (p % 5)] : 1'b0;
      logic drv_hi;
      always_comb begin
        case (func)
          pmrl_pkg::PMRL_PF_EXT_SUPPLY_ENABLE:  drv_hi = en_done;
          pmrl_pkg::PMRL_PF_POK_OUT: drv_hi = src_pok;
          pmrl_pkg::PMRL_PF_REG_OUT: drv_hi = reg_lvl;
          default:                   drv_hi = 1'b1;
        endcase
      end
      // Open drain: pull low when output low, release otherwise
      assign gpio_out[p]    = 1'b0;
      assign gpio_oe_out[p] = (func != pmrl_pkg::PMRL_PF_GPIO_IN) && !drv_hi;
    end
  endgenerate

  // External power-good on pin 0 in input mode triggers the last
  // regulator; the supply must drive it while in regulation.
  wire ext_good = (pin_dly_q[0][3] == 1'b0 && pin_func_lo_q[0] == 1'b0)
                  && gpio_sync[0];

  // Strap sampling, held until next power-up
  logic [1:0] st_b1_q, st_b3_q, st_l1_q, st_dl_q;
  logic       st_b2_q, st_l2_q, sampled_q;
  logic [1:0] sy_b1, sy_b3, sy_l1, sy_dl;
  logic       sy_b2, sy_l2;

  pmrl_pin_sync #(.W(10)) u_ssync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    ({strap_buck1_in, strap_buck3_in, strap_ldo1_in,
                 strap_delay_in, strap_buck2_in, strap_ldo2_in}),
    .level_out ({sy_b1, sy_b3, sy_l1, sy_dl, sy_b2, sy_l2})
  );

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sampled_q <= 1'b0;
      st_b1_q   <= 2'h1;
      st_b3_q   <= 2'h1;
      st_l1_q   <= 2'h1;
      st_dl_q   <= 2'h1;
      st_b2_q   <= 1'b1;
      st_l2_q   <= 1'b1;
    end else if (strap_sample_in && !sampled_q) begin
      sampled_q <= 1'b1;
      st_b1_q   <= sy_b1;
      st_b3_q   <= sy_b3;
      st_l1_q   <= sy_l1;
      st_dl_q   <= sy_dl;
      st_b2_q   <= sy_b2;
      st_l2_q   <= sy_l2;
    end
  end

  // Three-state encoding: 2'b11 high, 2'b00 low, otherwise float
  function automatic pmrl_pkg::pmrl_level_t lvl(input logic [1:0] s);
    lvl = (s == 2'h3) ? pmrl_pkg::PMRL_LVL_HIGH :
          (s == 2'h0) ? pmrl_pkg::PMRL_LVL_LOW : pmrl_pkg::PMRL_LVL_FLOAT;
  endfunction

  wire pmrl_pkg::pmrl_level_t l_b1 = lvl(st_b1_q);
  wire pmrl_pkg::pmrl_level_t l_b3 = lvl(st_b3_q);
  wire pmrl_pkg::pmrl_level_t l_l1 = lvl(st_l1_q);
  wire pmrl_pkg::pmrl_level_t l_dl = lvl(st_dl_q);

  // Presets are plain selectors; any register contents allowed
  always_comb begin
    case (l_b1)
      pmrl_pkg::PMRL_LVL_HIGH: begin
        buck1_op_out = pmrl_pkg::PMRL_OP_LSW;  buck1_preset_out = 2'h0;
      end
      pmrl_pkg::PMRL_LVL_FLOAT: begin
        buck1_op_out = pmrl_pkg::PMRL_OP_BUCK; buck1_preset_out = 2'h0;
      end
      default: begin
        buck1_op_out = pmrl_pkg::PMRL_OP_BUCK; buck1_preset_out = 2'h1;
      end
    endcase
    if (shared_pin_buck12_option_in) begin
      buck2_preset_out = (l_b1 == pmrl_pkg::PMRL_LVL_LOW) ?
        {1'b0, buck2_shared_preset_lo_in} : {1'b0, buck2_shared_preset_hi_in};
    end else begin
      buck2_preset_out = st_b2_q ? 2'h0 : 2'h1;
    end
    case (l_b3)
      pmrl_pkg::PMRL_LVL_HIGH:  buck3_preset_out = 2'h0;
      pmrl_pkg::PMRL_LVL_FLOAT: buck3_preset_out = 2'h1;
      default:                  buck3_preset_out = 2'h2;
    endcase
    case (l_l1)
      pmrl_pkg::PMRL_LVL_HIGH: begin
        ldo1_op_out = pmrl_pkg::PMRL_OP_LDO; ldo1_preset_out = 2'h0;
      end
      pmrl_pkg::PMRL_LVL_FLOAT: begin
        ldo1_op_out = pmrl_pkg::PMRL_OP_LSW; ldo1_preset_out = 2'h0;
      end
      default: begin
        ldo1_op_out = pmrl_pkg::PMRL_OP_LDO; ldo1_preset_out = 2'h1;
      end
    endcase
    // Shared option reuses the LDO1 strap, else the delay strap for Buck4
    if (shared_pin_ldo1_b4_option_in) begin
      if (l_l1 != pmrl_pkg::PMRL_LVL_FLOAT) begin
        buck4_op_out = pmrl_pkg::PMRL_OP_BUCK; buck4_preset_out = 2'h0;
      end else if (b4_default_operation_in) begin
        buck4_op_out = pmrl_pkg::PMRL_OP_BUCK; buck4_preset_out = 2'h1;
      end else begin
        buck4_op_out = pmrl_pkg::PMRL_OP_LDO;  buck4_preset_out = 2'h2;
      end
    end else begin
      case (l_dl)
        pmrl_pkg::PMRL_LVL_HIGH: begin
          buck4_op_out = pmrl_pkg::PMRL_OP_BUCK; buck4_preset_out = 2'h0;
        end
        pmrl_pkg::PMRL_LVL_FLOAT: begin
          buck4_op_out = pmrl_pkg::PMRL_OP_BUCK; buck4_preset_out = 2'h1;
        end
        default: begin
          buck4_op_out = pmrl_pkg::PMRL_OP_LDO;  buck4_preset_out = 2'h2;
        end
      endcase
    end
    ldo2_op_out = st_l2_q ? pmrl_pkg::PMRL_OP_LDO : pmrl_pkg::PMRL_OP_LSW;
  end

  // Start timing: normal delay code plus extra delay for Buck4/LDO1/LDO2
  // Extra fields: xtra_q = {b4 high, b4 float, b4 low, l1 high},
  // xtra2_q = {l1 float, l1 low, l2 high, l2 float}; LDO2 low is zero.
  wire [1:0] lvl_idx = (l_dl == pmrl_pkg::PMRL_LVL_HIGH) ? 2'd0 :
                       (l_dl == pmrl_pkg::PMRL_LVL_FLOAT) ? 2'd1 : 2'd2;
  wire [23:0] xf = {xtra_q, xtra2_q, 8'h00};

  genvar r;
  generate
    for (r = 0; r < NREG; r++) begin : g_reg
      logic [1:0]    xcode;
      logic [CW-1:0] scount;
      logic          trig;
      always_comb begin
        xcode = 2'h0;
        if (r >= 3) begin // regulators 3..5 = Buck4, LDO1, LDO2
          xcode = xf[23 - ((r - 3) * 6 + lvl_idx * 2) -: 2];
        end
        scount = CW'((startup_sel_in * 250 + pmrl_pkg::XTRA_DLY_US[xcode])
                     * pmrl_pkg::CYC_PER_US);
      end
      assign trig = (r == NREG - 1) ? (start_req_in[r] | ext_good)
                                    : start_req_in[r];
      pmrl_delay_timer #(.CW(CW)) u_st (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .arm_in   (trig && sampled_q),
        .count_in (scount),
        .done_out (reg_start_out[r])
      );
    end
  endgenerate

  // Readback, including live rail status
  always_comb begin
    case (reg_addr_in)
      pmrl_pkg::PIN_DLY_A_OFS:  reg_rdata_out = pin_dly_q[0];
      pmrl_pkg::PIN_DLY_B_OFS:  reg_rdata_out = pin_dly_q[1];
      pmrl_pkg::PIN_DLY_C_OFS:  reg_rdata_out = pin_dly_q[2];
      pmrl_pkg::PIN_DLY_D_OFS:  reg_rdata_out = pin_dly_q[3];
      pmrl_pkg::RST_SEL_OFS:    reg_rdata_out = rst_sel_q;
      pmrl_pkg::RST_CFG_OFS:    reg_rdata_out = rst_cfg_q;
      pmrl_pkg::PIN_FUNC_OFS:   reg_rdata_out = pin_func_lo_q;
      pmrl_pkg::PIN_SRC_OFS:    reg_rdata_out = pin_src_q;
      pmrl_pkg::EXTRA_DLY_OFS:  reg_rdata_out = xtra_q;
      pmrl_pkg::EXTRA_DLY2_OFS: reg_rdata_out = xtra2_q;
      pmrl_pkg::STATUS_OFS:
        reg_rdata_out = {rel_done, rails_good, power_ok_in};
      default:                  reg_rdata_out = 8'h00;
    endcase
  end
endmodule

// [verif/pmrl_core_monitor.sv]
/* Port checker for pmrl_core: pin drive, reset release and strap hold.
 * Assumes pin config writes land in the cycle after the write edge. */
`timescale 1ns/1ps
module pmrl_core_monitor #(
  parameter int NREG = 6,
  parameter int NPIN = 8
) (
  input wire logic            clk_in,
  input wire logic            rstn_in,
  input wire logic            reg_wr_in,
  input wire logic [7:0]      reg_addr_in,
  input wire logic [7:0]      reg_wdata_in,
  input wire logic [NREG-1:0] power_ok_in,
  input wire logic            strap_sample_in,
  input wire logic            shared_pin_buck12_option_in,
  input wire logic            buck2_shared_preset_hi_in,
  input wire logic            shared_pin_ldo1_b4_option_in,
  input wire logic [NPIN-1:0] gpio_out,
  input wire logic [NPIN-1:0] gpio_oe_out,
  input wire logic            system_reset_out_n,
  input wire logic            system_reset_oe_out,
  input wire logic [1:0]      buck1_op_out,
  input wire logic [1:0]      buck2_preset_out,
  input wire logic [1:0]      buck4_op_out,
  input wire logic [1:0]      buck4_preset_out,
  input wire logic [1:0]      ldo1_op_out
);
  logic [7:0]  fb_q, fc_q, f2_q, f3_q;
  logic [15:0] hc_q;
  logic [19:0] pc_q;
  logic [3:0]  sc_q;
  int unsigned wt;
  wire         rp1 = fb_q[7] & f2_q[1];
  wire         pp2 = fc_q[3] & ~f2_q[2];
  wire         ee3 = ~fc_q[7] & f2_q[3];
  assign wt = pmrl_pkg::EXT_DLY_US[fc_q[6:4]] * pmrl_pkg::CYC_PER_US;
  // Shadow only the pin config; the rest is judged by the bench
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {fb_q, fc_q, f2_q, f3_q} <= '0;
      {hc_q, pc_q, sc_q} <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h0b) fb_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h0c) fc_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h42) f2_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h43) f3_q <= reg_wdata_in;
      hc_q <= system_reset_oe_out ? hc_q + 16'(hc_q != 16'hffff) : '0;
      pc_q <= power_ok_in[f3_q[2:0]] ? pc_q + 20'h1 : '0;
      if ((strap_sample_in || sc_q != 4'h0) && sc_q != 4'hf)
        sc_q <= sc_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_open_drain: assert property (gpio_out == '0 && !system_reset_out_n)
    else $error("pin data line not held low");
  a_release_wait: assert property ($fell(system_reset_oe_out)
    |-> hc_q >= 16'hc350) else $error("reset released too early");
  a_ext_delay: assert property ($fell(gpio_oe_out[3]) && ee3
    |-> pc_q >= wt[19:0]) else $error("supply enable too early");
  a_reg_level: assert property ((rp1 && $stable(f3_q))[*4]
    |-> gpio_oe_out[1] == !f3_q[4]) else $error("register pin level wrong");
  a_pok_route: assert property ((pp2 && $stable(power_ok_in)
    && $stable(f3_q))[*5] |-> gpio_oe_out[2] == !power_ok_in[f3_q[2:0]])
    else $error("routed power ok wrong");
  a_straps_hold: assert property (sc_q == 4'hf |=> $stable({buck1_op_out,
    buck2_preset_out, buck4_op_out, buck4_preset_out, ldo1_op_out}))
    else $error("decoded mode moved");
  a_shared_b4: assert property (sc_q == 4'hf
    && shared_pin_ldo1_b4_option_in && ldo1_op_out == 2'h1
    |-> buck4_op_out == 2'h0 && buck4_preset_out == 2'h0)
    else $error("shared buck4 decode wrong");
  a_shared_b12: assert property (sc_q == 4'hf
    && shared_pin_buck12_option_in && buck1_op_out == 2'h2
    |-> buck2_preset_out == {1'b0, buck2_shared_preset_hi_in})
    else $error("shared buck2 preset wrong");
  cover property ($fell(system_reset_oe_out));
  cover property ($fell(gpio_oe_out[3]) && ee3);
  cover property (sc_q == 4'hf && shared_pin_buck12_option_in);
endmodule

// [verif/pmrl_ext_supply.sv]
/* External supply: power good follows its enable after a ramp.
 * Assumes the enable pin level is already resolved by the bench. */
`timescale 1ns/1ps
module pmrl_ext_supply #(
  parameter int GOOD_DLY = 20
) (
  input  wire logic clk_in,
  input  wire logic en_in,
  output logic      good_out
);
  int cnt;
  initial good_out = 1'b0;
  initial cnt = 0;
  // Ramp before good
  always @(posedge clk_in) begin
    if (!en_in) begin
      cnt <= 0;
      good_out <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      good_out <= cnt >= GOOD_DLY;
    end
  end
endmodule

// [verif/tb_pmic_pin_mode_reset_logic.sv]
/* Bench for pmrl_core: straps, register map, pins and reset release.
 * Assumes open-drain pins pulled up; pin 0 driven by the supply model. */
`timescale 1ns/1ps
bind pmrl_core pmrl_core_monitor #(.NREG(NREG), .NPIN(NPIN)) mon (.*);
module tb_pmic_pin_mode_reset_logic;
  logic       clk_in, rstn_in, reg_wr_in, strap_buck2_in, strap_ldo2_in;
  logic       strap_sample_in, shared_pin_buck12_option_in, ext_good;
  logic       buck2_shared_preset_hi_in, buck2_shared_preset_lo_in;
  logic       shared_pin_ldo1_b4_option_in, b4_default_operation_in;
  logic       system_reset_out_n, system_reset_oe_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, gpio_in, gpio_out;
  logic [7:0] gpio_oe_out;
  logic [5:0] power_ok_in, reg_enabled_in, start_req_in, reg_start_out;
  logic [2:0] startup_sel_in;
  logic [1:0] strap_buck1_in, strap_buck3_in, strap_ldo1_in, strap_delay_in;
  logic [1:0] buck1_op_out, buck1_preset_out, buck2_preset_out;
  logic [1:0] buck3_preset_out, buck4_op_out, buck4_preset_out;
  logic [1:0] ldo1_op_out, ldo1_preset_out, ldo2_op_out;
  logic [7:0] ra [9] = '{8'h0b, 8'h0c, 8'h27, 8'h28, 8'h40, 8'h41, 8'h42,
                         8'h43, 8'h44};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h01, 8'h00,
                         8'h00, 8'h00};
  int         err_count, checks_done, t3, n;
  // Pull-ups on pins 1..7; pin 0 is pushed by the supply
  assign gpio_in = ~gpio_oe_out & {7'h7f, ext_good};
  pmrl_core #(.NREG(6), .NPIN(8), .CW(23)) uut (.*);
  pmrl_ext_supply #(.GOOD_DLY(20)) sup (.clk_in, .en_in(gpio_in[3]),
    .good_out(ext_good));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_in);
    reg_addr_in = a;
    #1 chk($sformatf("register %h", a), e, reg_rdata_out);
  endtask
  function automatic logic [17:0] want(input int p, l);
    logic [1:0] o, s;
    o = (p == 0 ? l == 2 : (l == 1 && p == 1)) ? 2'h1 : 2'h0;
    s = o == 2'h1 ? 2'h2 : (l == 1 ? 2'h1 : 2'h0);
    return {l == 0 ? 2'h2 : 2'h0, l == 2 ? 2'h1 : 2'h0,
            (p == 1 ? l != 2 : l == 2) ? 2'h1 : 2'h0, 2'(l), o, s,
            l == 1 ? 2'h2 : 2'h1, l == 2 ? 2'h1 : 2'h0, l == 2 ? 2'h2 : 2'h1};
  endfunction
  // Straps are sampled once per power-up, so each case needs a reset
  task automatic strap_case(input int p, l);
    logic [1:0] lv;
    lv = l == 0 ? 2'b11 : (l == 1 ? 2'b01 : 2'b00);
    rstn_in = 1'b0;
    strap_sample_in = 1'b0;
    strap_buck1_in = lv;
    strap_buck3_in = lv;
    strap_ldo1_in = lv;
    strap_delay_in = p == 0 ? lv : 2'b01;
    strap_buck2_in = p == 0 ? l != 2 : l == 2;
    strap_ldo2_in = l != 2;
    shared_pin_buck12_option_in = p != 0;
    shared_pin_ldo1_b4_option_in = p != 0;
    buck2_shared_preset_hi_in = p == 1;
    buck2_shared_preset_lo_in = p == 2;
    b4_default_operation_in = p == 2;
    repeat (12) @(negedge clk_in);
    rstn_in = 1'b1;
    // Strap synchroniser needs a few edges to settle
    repeat (6) @(negedge clk_in);
    strap_sample_in = 1'b1;
    repeat (16) @(negedge clk_in);
    for (int k = 0; k < 2; k++) begin
      chk("decoded modes", want(p, l), {buck1_op_out, l == 0 ? 2'h0 :
        buck1_preset_out, buck2_preset_out, buck3_preset_out, buck4_op_out,
        buck4_preset_out, ldo1_op_out, l == 1 ? 2'h0 : ldo1_preset_out,
        ldo2_op_out});
      strap_buck1_in = ~lv;
      strap_buck3_in = ~lv;
      strap_ldo1_in = ~lv;
      strap_delay_in = ~lv;
      strap_buck2_in = ~strap_buck2_in;
      strap_ldo2_in = ~strap_ldo2_in;
      repeat (8) @(negedge clk_in);
    end
  endtask
  // Twice the release wait
  initial begin
    #1000000;
    err_count++;
    wrap_up;
  end
  initial begin
    {reg_wr_in, reg_addr_in, reg_wdata_in, power_ok_in} = '0;
    {start_req_in, startup_sel_in} = '0;
    reg_enabled_in = 6'h3f;
    for (int p = 0; p < 3; p++) for (int l = 0; l < 3; l++) strap_case(p, l);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h99, 8'h5a);
    rd(8'h99, 8'h00);
    power_ok_in = 6'h3f;
    rd(pmrl_pkg::STATUS_OFS, 8'h7f);
    power_ok_in = 6'h3b;
    rd(pmrl_pkg::STATUS_OFS, 8'h3b);
    chk("reset pin drive", 1, system_reset_oe_out);
    wr(pmrl_pkg::RST_SEL_OFS, 8'h3b);
    rd(pmrl_pkg::STATUS_OFS, 8'h7b);
    reg_enabled_in = 6'h37;
    power_ok_in = 6'h33;
    rd(pmrl_pkg::STATUS_OFS, 8'h73);
    wr(pmrl_pkg::RST_CFG_OFS, 8'h00);
    rd(pmrl_pkg::STATUS_OFS, 8'h33);
    wr(pmrl_pkg::RST_CFG_OFS, 8'h01);
    wr(pmrl_pkg::RST_SEL_OFS, 8'h3f);
    reg_enabled_in = 6'h3f;
    power_ok_in = 6'h2f;
    wr(pmrl_pkg::PIN_DLY_A_OFS, 8'h80);
    wr(pmrl_pkg::PIN_DLY_B_OFS, 8'h18);
    wr(pmrl_pkg::PIN_FUNC_OFS, 8'h0a);
    wr(pmrl_pkg::PIN_SRC_OFS, 8'h04);
    repeat (8) @(negedge clk_in);
    chk("pin drive", 8'h0e, gpio_oe_out);
    wr(pmrl_pkg::PIN_SRC_OFS, 8'h14);
    rd(pmrl_pkg::PIN_SRC_OFS, 8'h14);
    chk("pin drive", 8'h0c, gpio_oe_out);
    power_ok_in = 6'h3f;
    t3 = 0;
    for (n = 0; n < 60000 && system_reset_oe_out; n++) begin
      @(negedge clk_in);
      if (!gpio_oe_out[3] && t3 == 0) t3 = n + 1;
    end
    chk("release time", 1, n >= 50000 && n <= 50010);
    chk("enable delay", 1, t3 >= 25000 && t3 <= 25010);
    chk("pin drive", 8'h00, gpio_oe_out);
    chk("regulator start", 6'h20, reg_start_out);
    rd(pmrl_pkg::STATUS_OFS, 8'hff);
    power_ok_in = 6'h3e;
    repeat (3) @(negedge clk_in);
    chk("reset pin drive", 1, system_reset_oe_out);
    wrap_up;
  end
endmodule
